/* eecfg_pkg.sv */
/*
 * Shared constants for the EEPROM configuration program loader:
 * word field positions, header signature, zone selectors, writable
 * PCI configuration offsets, register-bus map and serial timing.
 * Assumes a single 200 MHz clock domain.
 */
package eecfg_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned EE_SK_NS = 1000;
    localparam int unsigned EE_HALF_CYC = (EE_SK_NS * CLK_MHZ) / 2000;
    localparam logic [7:0] EE_HALF_M1 = 8'(EE_HALF_CYC - 1);

    localparam int unsigned WORD_W = 16;
    localparam int unsigned ADDR_W = 8;
    localparam logic [2:0] EE_READ_OP = 3'h6;
    localparam logic [4:0] EE_CMD_BITS = 5'h0B;
    localparam logic [4:0] EE_DATA_BITS = 5'h10;
    localparam logic [4:0] EE_DUMMY_BITS = 5'h01;

    localparam int unsigned B_MORE = 15;
    localparam int unsigned B_OFS_HI = 14;
    localparam int unsigned B_OFS_LO = 8;
    localparam int unsigned B_SIG_HI = 15;
    localparam int unsigned B_SIG_LO = 4;
    localparam int unsigned B_Z1 = 3;
    localparam int unsigned B_Z2 = 2;
    localparam int unsigned B_Z3 = 1;
    localparam int unsigned B_Z4 = 0;
    localparam int unsigned B_FN_HI = 2;
    // Arbitrary signature value, chosen for this block
    localparam logic [11:0] HDR_SIGNATURE = 12'hA5C;
    localparam logic [2:0] FUNC_ZERO = 3'h0;

    localparam logic [6:0] ID_VEN_LO = 7'h00;
    localparam logic [6:0] ID_VEN_HI = 7'h01;
    localparam logic [6:0] ID_SVEN_LO = 7'h02;
    localparam logic [6:0] ID_SVEN_HI = 7'h03;

    localparam logic [6:0] CFG_DEVID_LO = 7'h02;
    localparam logic [6:0] CFG_DEVID_HI = 7'h03;
    localparam logic [6:0] CFG_STATUS = 7'h06;
    localparam logic [7:0] CFG_STATUS_MASK = 8'h10;
    localparam logic [6:0] CFG_CLASS_LO = 7'h09;
    localparam logic [6:0] CFG_CLASS_HI = 7'h0B;
    localparam logic [6:0] CFG_SSID_LO = 7'h2E;
    localparam logic [6:0] CFG_SSID_HI = 7'h2F;
    localparam logic [6:0] CFG_INTPIN = 7'h3D;
    localparam logic [6:0] CFG_PM_LO = 7'h42;
    localparam logic [6:0] CFG_PM_HI = 7'h43;

    // Local registers the program may write (byte offsets), as a 128-bit mask
    localparam logic [127:0] LOCAL_WR_MASK = 128'h0000_0000_0000_0000_0000_0000_FFFF_FFF0;

    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_WORDS = 4'h8;
    localparam int unsigned B_VALID = 28;
    localparam int unsigned B_RELOAD = 29;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    typedef enum logic [1:0] {EECFG_Z_LOCAL, EECFG_Z_ID, EECFG_Z_PCI, EECFG_Z_FUNC} eecfg_zone_e;

    // First enabled zone at or after the given one; 3'h4 means none remain
    function automatic logic [2:0] eecfg_next_zone(input logic [3:0] en, input logic [2:0] after);
        logic [2:0] r;
        r = 3'h4;
        for (int i = 3; i >= 0; i--) begin
            if (en[3 - i] && (3'(i) >= after)) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction
endpackage

/* eecfg_serial_reader.sv */
/*
 * Serial EEPROM word reader: shifts out a read command and address,
 * then shifts in one 16-bit word MSB first.
 * Assumes the EEPROM drives data out on the falling serial clock.
 */
`timescale 1ns/1ps
`default_nettype none
module eecfg_serial_reader
    import eecfg_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_start,
    input wire logic [eecfg_pkg::ADDR_W-1:0] i_addr,
    input wire logic i_ee_do,
    output logic o_ee_cs,
    output logic o_ee_sk,
    output logic o_ee_di,
    output logic o_busy,
    output logic o_done,
    output logic [eecfg_pkg::WORD_W-1:0] o_data
);
    typedef enum logic [1:0] {EECFG_R_IDLE, EECFG_R_CMD, EECFG_R_DATA, EECFG_R_END} eecfg_rd_e;
    eecfg_rd_e state_ff;
    logic [7:0] div_ff;
    logic [4:0] cnt_ff;
    logic [10:0] shout_ff;
    logic tick;

    assign tick = (div_ff == EE_HALF_M1);
    assign o_busy = (state_ff != EECFG_R_IDLE);

    always_ff @(posedge i_clock) begin
        if (i_srst || state_ff == EECFG_R_IDLE || tick) begin
            div_ff <= 8'h00;
        end else begin
            div_ff <= div_ff + 8'h01;
        end
    end

    // Word fetch: command and address out, data in
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_ff <= EECFG_R_IDLE;
            o_ee_cs <= 1'b0;
            o_ee_sk <= 1'b0;
            o_ee_di <= 1'b0;
            o_done <= 1'b0;
            o_data <= '0;
            cnt_ff <= '0;
            shout_ff <= '0;
        end else begin
            o_done <= 1'b0;
            unique case (state_ff)
                EECFG_R_IDLE: begin
                    if (i_start) begin
                        state_ff <= EECFG_R_CMD;
                        o_ee_cs <= 1'b1;
                        o_ee_di <= EE_READ_OP[2];
                        shout_ff <= {EE_READ_OP[1:0], i_addr, 1'b0};
                        cnt_ff <= EE_CMD_BITS;
                    end
                end
                EECFG_R_CMD: begin
                    if (tick) begin
                        o_ee_sk <= ~o_ee_sk;
                        if (o_ee_sk) begin
                            // Bit changes on the fall, steady at the rise
                            o_ee_di <= shout_ff[10];
                            shout_ff <= {shout_ff[9:0], 1'b0};
                            if (cnt_ff == EE_DUMMY_BITS) begin
                                state_ff <= EECFG_R_DATA;
                                cnt_ff <= EE_DATA_BITS;
                            end else begin
                                cnt_ff <= cnt_ff - 5'h01;
                            end
                        end
                    end
                end
                EECFG_R_DATA: begin
                    if (tick) begin
                        o_ee_sk <= ~o_ee_sk;
                        if (!o_ee_sk) begin
                            o_data <= {o_data[WORD_W-2:0], i_ee_do};
                            cnt_ff <= cnt_ff - 5'h01;
                        end else if (cnt_ff == 5'h00) begin
                            state_ff <= EECFG_R_END;
                        end
                    end
                end
                EECFG_R_END: begin
                    o_ee_cs <= 1'b0;
                    o_ee_di <= 1'b0;
                    o_done <= 1'b1;
                    state_ff <= EECFG_R_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* eecfg_avmm_regs.sv */
/*
 * Avalon-MM slave for the loader's control and status words.
 * Assumes a master that holds each request until waitrequest is low.
 */
`timescale 1ns/1ps
`default_nettype none
module eecfg_avmm_regs
    import eecfg_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [3:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic i_valid,
    input wire logic i_loading,
    input wire logic [7:0] i_words,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    output logic o_reload
);
    // Idles high, drops for the one cycle that answers a request
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_waitrequest <= 1'b1;
        end else begin
            o_waitrequest <= !((i_read || i_write) && o_waitrequest);
        end
    end

    // Writing 1 to bit 29 restarts the load
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_reload <= 1'b0;
        end else begin
            o_reload <= i_write && !o_waitrequest && (i_address == REG_CTRL)
                && i_writedata[B_RELOAD];
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_readdata <= '0;
        end else if (i_read && o_waitrequest) begin
            unique case (i_address)
                REG_CTRL: o_readdata <= 32'(i_valid) << B_VALID;
                REG_STATUS: o_readdata <= {31'h0, i_loading};
                REG_WORDS: o_readdata <= {24'h0, i_words};
                default: o_readdata <= UNMAPPED_RD;
            endcase
        end
    end
endmodule
`default_nettype wire

/* eecfg_loader.sv */
/*
 * EEPROM configuration program parser. Fetches 16-bit words, checks the
 * header, walks the enabled zones and emits byte writes to the local
 * registers, identification bytes, PCI configuration bytes and function
 * accesses. Assumes the device retries PCI accesses while o_retry is high.
 */
// Summary of operation
// - Signature match sets valid bit 28
// - Header bits 3..0 enable zones 1..4
// - Present zones follow back to back
// - Zone1 word: offset 14:8, data 7:0
// - Zone1 bit 15 chains next word
// - Non-writable local registers stay unchanged
// - Zone2 selectors pick vendor identifier bytes
// - Zone2 bit 15 chains next byte
// - Zone3 header bit 15 opens function
// - Zone3 data word writes PCI byte
// - Zone3 writes only allowed identifier bytes
// - Interrupt pin, PM bytes, status bit 4
// - Control bit 29 restarts the load
// - Load starts after reset, ends at end
// - PCI accesses retried while loading
// - Serial read command, address, data word
// - Zone4 pairs; second word bit 15 chains next pair
`timescale 1ns/1ps
`default_nettype none
module eecfg_loader
    import eecfg_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [3:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    input wire logic i_ee_do,
    output logic o_ee_cs,
    output logic o_ee_sk,
    output logic o_ee_di,
    output logic o_retry,
    output logic o_valid,
    output logic o_local_we,
    output logic [6:0] o_local_ofs,
    output logic [7:0] o_local_data,
    output logic o_id_we,
    output logic [1:0] o_id_sel,
    output logic [7:0] o_id_data,
    output logic o_cfg_we,
    output logic [6:0] o_cfg_ofs,
    output logic [7:0] o_cfg_data,
    output logic o_func_we,
    output logic o_func_is_write,
    output logic [2:0] o_func_bar,
    output logic [7:0] o_func_addr,
    output logic [7:0] o_func_data
);
    typedef enum logic [2:0] {
        EECFG_S_IDLE, EECFG_S_FETCH, EECFG_S_WAIT, EECFG_S_PARSE, EECFG_S_DONE
    } eecfg_st_e;
    typedef enum logic [2:0] {
        EECFG_W_HDR, EECFG_W_Z1, EECFG_W_Z2, EECFG_W_FHDR, EECFG_W_FDATA,
        EECFG_W_Z4A, EECFG_W_Z4B
    } eecfg_word_e;

    eecfg_st_e state_ff;
    eecfg_word_e kind_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [3:0] zen_ff;
    logic fn_ok_ff;
    logic [WORD_W-1:0] z4a_ff;
    logic [7:0] words_ff;
    logic rd_start;
    logic rd_busy;
    logic rd_done;
    logic [WORD_W-1:0] rd_data;
    logic reload;
    logic [6:0] ofs;
    logic more;
    logic reload_pend_ff;
    logic reload_go;

    assign ofs = rd_data[B_OFS_HI:B_OFS_LO];
    assign more = rd_data[B_MORE];
    assign rd_start = (state_ff == EECFG_S_FETCH);
    assign reload_go = (reload || reload_pend_ff) && !rd_busy
        && state_ff != EECFG_S_FETCH && state_ff != EECFG_S_WAIT;

    eecfg_serial_reader u_reader (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_start(rd_start),
        .i_addr(addr_ff),
        .i_ee_do(i_ee_do),
        .o_ee_cs(o_ee_cs),
        .o_ee_sk(o_ee_sk),
        .o_ee_di(o_ee_di),
        .o_busy(rd_busy),
        .o_done(rd_done),
        .o_data(rd_data)
    );

    eecfg_avmm_regs u_regs (
        .i_clock(i_clock),
        .i_srst(i_srst),
        .i_address(i_address),
        .i_read(i_read),
        .i_write(i_write),
        .i_writedata(i_writedata),
        .i_valid(o_valid),
        .i_loading(o_retry),
        .i_words(words_ff),
        .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest),
        .o_reload(reload)
    );

    function automatic eecfg_word_e zone_kind(input logic [2:0] z);
        unique case (z)
            3'h0: return EECFG_W_Z1;
            3'h1: return EECFG_W_Z2;
            3'h2: return EECFG_W_FHDR;
            default: return EECFG_W_Z4A;
        endcase
    endfunction

    // Zone 3 writable bytes; vendor identifiers are not among them
    function automatic logic cfg_writable(input logic [6:0] o);
        return (o == CFG_DEVID_LO) || (o == CFG_DEVID_HI) || (o == CFG_STATUS)
            || (o >= CFG_CLASS_LO && o <= CFG_CLASS_HI)
            || (o == CFG_SSID_LO) || (o == CFG_SSID_HI) || (o == CFG_INTPIN)
            || (o == CFG_PM_LO) || (o == CFG_PM_HI);
    endfunction

    // First enabled zone at or after the given one, or 3'h4 when none is enabled at or after it
    function automatic logic [2:0] after_zone(input logic [3:0] en, input logic [2:0] z);
        return eecfg_next_zone(en, z);
    endfunction

    // Reload waits while a word is in flight
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            reload_pend_ff <= 1'b0;
        end else begin
            reload_pend_ff <= (reload || reload_pend_ff) && !reload_go;
        end
    end

    // Sequencing; a reload request restarts from the header
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_ff <= EECFG_S_FETCH;
            kind_ff <= EECFG_W_HDR;
            addr_ff <= '0;
            zen_ff <= '0;
            fn_ok_ff <= 1'b0;
            z4a_ff <= '0;
            words_ff <= '0;
        end else if (reload_go) begin
            state_ff <= EECFG_S_FETCH;
            kind_ff <= EECFG_W_HDR;
            addr_ff <= '0;
            words_ff <= '0;
        end else begin
            unique case (state_ff)
                EECFG_S_IDLE, EECFG_S_DONE: begin
                end
                EECFG_S_FETCH: state_ff <= EECFG_S_WAIT;
                EECFG_S_WAIT: begin
                    if (rd_done) begin
                        state_ff <= EECFG_S_PARSE;
                        addr_ff <= addr_ff + 8'h01;
                        words_ff <= words_ff + 8'h01;
                    end
                end
                EECFG_S_PARSE: begin
                    state_ff <= EECFG_S_FETCH;
                    unique case (kind_ff)
                        EECFG_W_HDR: begin
                            // A bad signature ends the load with nothing applied
                            zen_ff <= rd_data[B_Z1:B_Z4];
                            if (rd_data[B_SIG_HI:B_SIG_LO] != HDR_SIGNATURE) begin
                                state_ff <= EECFG_S_DONE;
                            end else if (after_zone(rd_data[B_Z1:B_Z4], 3'h0) == 3'h4) begin
                                state_ff <= EECFG_S_DONE;
                            end else begin
                                kind_ff <= zone_kind(after_zone(rd_data[B_Z1:B_Z4], 3'h0));
                            end
                        end
                        EECFG_W_Z1, EECFG_W_Z2: begin
                            // Chain bit keeps the zone
                            if (!more) begin
                                if (after_zone(zen_ff, (kind_ff == EECFG_W_Z1) ? 3'h1 : 3'h2)
                                        == 3'h4) begin
                                    state_ff <= EECFG_S_DONE;
                                end else begin
                                    kind_ff <= zone_kind(after_zone(zen_ff,
                                        (kind_ff == EECFG_W_Z1) ? 3'h1 : 3'h2));
                                end
                            end
                        end
                        EECFG_W_FHDR: begin
                            // Closed zone 3 moves on; open function takes data
                            fn_ok_ff <= (rd_data[B_OFS_HI:B_FN_HI+1] == '0)
                                && (rd_data[B_FN_HI:0] == FUNC_ZERO);
                            if (more) begin
                                kind_ff <= EECFG_W_FDATA;
                            end else if (!zen_ff[B_Z4]) begin
                                state_ff <= EECFG_S_DONE;
                            end else begin
                                kind_ff <= EECFG_W_Z4A;
                            end
                        end
                        EECFG_W_FDATA: begin
                            if (!more) begin
                                kind_ff <= EECFG_W_FHDR;
                            end
                        end
                        EECFG_W_Z4A: begin
                            z4a_ff <= rd_data;
                            kind_ff <= EECFG_W_Z4B;
                        end
                        EECFG_W_Z4B: begin
                            if (more) begin
                                kind_ff <= EECFG_W_Z4A;
                            end else begin
                                state_ff <= EECFG_S_DONE;
                            end
                        end
                    endcase
                end
                default: state_ff <= EECFG_S_IDLE;
            endcase
        end
    end

    // Retry termination while loading; valid bit on signature match
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_retry <= 1'b1;
            o_valid <= 1'b0;
        end else begin
            o_retry <= (state_ff != EECFG_S_DONE) && (state_ff != EECFG_S_IDLE);
            if (reload_go) begin
                o_valid <= 1'b0;
            end else if (state_ff == EECFG_S_PARSE && kind_ff == EECFG_W_HDR) begin
                o_valid <= (rd_data[B_SIG_HI:B_SIG_LO] == HDR_SIGNATURE);
            end
        end
    end

    // Byte write strobes, one cycle each, only after a valid header
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_local_we <= 1'b0;
            o_local_ofs <= '0;
            o_local_data <= '0;
            o_id_we <= 1'b0;
            o_id_sel <= '0;
            o_id_data <= '0;
            o_cfg_we <= 1'b0;
            o_cfg_ofs <= '0;
            o_cfg_data <= '0;
            o_func_we <= 1'b0;
            o_func_is_write <= 1'b0;
            o_func_bar <= '0;
            o_func_addr <= '0;
            o_func_data <= '0;
        end else begin
            o_local_we <= 1'b0;
            o_id_we <= 1'b0;
            o_cfg_we <= 1'b0;
            o_func_we <= 1'b0;
            if (state_ff == EECFG_S_PARSE) begin
                o_local_ofs <= ofs;
                o_local_data <= rd_data[7:0];
                o_cfg_ofs <= ofs;
                o_id_data <= rd_data[7:0];
                o_id_sel <= ofs[1:0];
                // Status byte keeps only the extended-capabilities bit
                o_cfg_data <= (ofs == CFG_STATUS) ? (rd_data[7:0] & CFG_STATUS_MASK)
                                                  : rd_data[7:0];
                o_func_is_write <= z4a_ff[11];
                o_func_bar <= z4a_ff[14:12];
                o_func_addr <= z4a_ff[7:0];
                o_func_data <= rd_data[7:0];
                unique case (kind_ff)
                    EECFG_W_Z1: o_local_we <= LOCAL_WR_MASK[ofs];
                    EECFG_W_Z2: o_id_we <= (ofs <= ID_SVEN_HI);
                    EECFG_W_FDATA: o_cfg_we <= fn_ok_ff && cfg_writable(ofs);
                    EECFG_W_Z4B: o_func_we <= 1'b1;
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* eecfg_loader_sva.sv */
/*
 * Checker for the configuration program loader's top ports.
 * Assumes one clock domain with a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module eecfg_loader_sva
    import eecfg_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [3:0] i_address,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic o_waitrequest,
    input wire logic o_ee_cs,
    input wire logic o_retry,
    input wire logic o_valid,
    input wire logic o_local_we,
    input wire logic [6:0] o_local_ofs,
    input wire logic o_id_we,
    input wire logic o_cfg_we,
    input wire logic [6:0] o_cfg_ofs,
    input wire logic [7:0] o_cfg_data,
    input wire logic o_func_we
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);
    logic any_we;
    assign any_we = o_local_we | o_id_we | o_cfg_we | o_func_we;
    retry_after_reset_a: assert property ($fell(i_srst) |-> o_retry)
        else $error("retry low right after reset");
    write_in_load_a: assert property (any_we |-> o_retry)
        else $error("byte write outside a load");
    one_target_a: assert property ($onehot0({o_local_we, o_id_we, o_cfg_we, o_func_we}))
        else $error("two write strobes together");
    write_pulse_a: assert property (any_we |=> !any_we)
        else $error("write strobe longer than one cycle");
    valid_in_load_a: assert property ($rose(o_valid) |-> o_retry)
        else $error("valid set outside a load");
    cfg_target_a: assert property (o_cfg_we |-> o_cfg_ofs inside {7'h02, 7'h03, 7'h06, 7'h09,
        7'h0A, 7'h0B, 7'h2E, 7'h2F, 7'h3D, 7'h42, 7'h43})
        else $error("config write to a locked byte");
    status_bits_a: assert property (o_cfg_we && o_cfg_ofs == 7'h06 |-> o_cfg_data[7:5] == 3'h0
        && o_cfg_data[3:0] == 4'h0)
        else $error("status byte write beyond bit 4");
    local_mask_a: assert property (o_local_we |-> LOCAL_WR_MASK[o_local_ofs])
        else $error("local write to a locked register");
    reload_start_a: assert property (i_write && !o_waitrequest && i_address == REG_CTRL
        && i_writedata[29] |-> ##[0:3] o_retry)
        else $error("reload did not start");
    link_idle_a: assert property (!o_retry |-> !o_ee_cs)
        else $error("serial select active after the load");
    cover property ($rose(o_valid));
    cover property (o_func_we);
    cover property ($rose(o_retry));
endmodule
bind eecfg_loader eecfg_loader_sva chk_u (.i_clock(i_clock), .i_srst(i_srst),
    .i_address(i_address), .i_write(i_write), .i_writedata(i_writedata),
    .o_waitrequest(o_waitrequest), .o_ee_cs(o_ee_cs), .o_retry(o_retry), .o_valid(o_valid),
    .o_local_we(o_local_we), .o_local_ofs(o_local_ofs), .o_id_we(o_id_we),
    .o_cfg_we(o_cfg_we), .o_cfg_ofs(o_cfg_ofs), .o_cfg_data(o_cfg_data),
    .o_func_we(o_func_we));
`default_nettype wire

/* eecfg_eeprom_model.sv */
/*
 * Behavioural serial EEPROM of 16-bit words, read command only.
 * Assumes the reader changes data in while the serial clock is low.
 */
`timescale 1ns/1ps
`default_nettype none
module eecfg_eeprom_model (
    input wire logic i_cs,
    input wire logic i_sk,
    input wire logic i_di,
    output logic o_do
);
    logic [15:0] mem [0:255];
    logic [7:0] addr_ff;
    logic [15:0] shift_ff;
    int n_bits;
    initial o_do = 1'b1;
    always @(posedge i_cs) n_bits = 0;
    // Released line: show the inverse so a stale value is never mistaken for data
    always @(negedge i_cs) o_do = ~o_do;
    always @(posedge i_sk) begin
        if (i_cs) begin
            n_bits++;
            if (n_bits > 3 && n_bits <= 11) addr_ff = {addr_ff[6:0], i_di};
            if (n_bits == 11) shift_ff = mem[addr_ff];
        end
    end
    always @(negedge i_sk) begin
        if (i_cs && n_bits >= 11) begin
            o_do = shift_ff[15];
            shift_ff = {shift_ff[14:0], 1'b0};
        end
    end
endmodule
`default_nettype wire

/* test_eecfg_loader.sv */
/*
 * Self-checking bench: loads a program holding every zone, then reloads
 * a program with a broken signature. Assumes the partner EEPROM model.
 */
`timescale 1ns/1ps
`default_nettype none
module test_eecfg_loader;
    import eecfg_pkg::*;
    logic i_clock = 1'b0;
    logic i_srst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, rs;
    logic waitreq, ee_do, cs, sk, di, retry, valid, lwe, iwe, cwe, fwe, fisw;
    logic [6:0] lofs, cofs;
    logic [1:0] isel;
    logic [2:0] fbar;
    logic [7:0] ldat, idat, cdat, faddr, fdat;
    logic [23:0] got;
    logic [23:0] expq[$];
    int mismatches = 0;
    int n_compared = 0;
    always #2.5 i_clock = ~i_clock;
    eecfg_eeprom_model ee_u (.i_cs(cs), .i_sk(sk), .i_di(di), .o_do(ee_do));
    eecfg_loader dut_u (.i_clock(i_clock), .i_srst(i_srst), .i_address(addr), .i_read(rd),
        .i_write(wr), .i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(waitreq),
        .i_ee_do(ee_do), .o_ee_cs(cs), .o_ee_sk(sk), .o_ee_di(di), .o_retry(retry),
        .o_valid(valid), .o_local_we(lwe), .o_local_ofs(lofs), .o_local_data(ldat),
        .o_id_we(iwe), .o_id_sel(isel), .o_id_data(idat), .o_cfg_we(cwe), .o_cfg_ofs(cofs),
        .o_cfg_data(cdat), .o_func_we(fwe), .o_func_is_write(fisw), .o_func_bar(fbar),
        .o_func_addr(faddr), .o_func_data(fdat));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("Compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int i;
        @(posedge i_clock);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        for (i = 0; i < 50; i++) begin
            @(posedge i_clock);
            if (waitreq === 1'b0) break;
        end
        if (i == 50) begin
            mismatches++;
            stop_test();
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic wait_done(input int lim);
        int k;
        for (k = 0; k < lim && retry !== 1'b0; k++) @(posedge i_clock);
        if (k == lim) begin
            mismatches++;
            stop_test();
        end
    endtask
    // Each strobe takes the oldest expected write off the queue
    always @(posedge i_clock) begin
        if (!i_srst && (lwe | iwe | cwe | fwe)) begin
            got = lwe ? {8'h10, 1'b0, lofs, ldat} : iwe ? {8'h20, 6'h0, isel, idat} :
                  cwe ? {8'h30, 1'b0, cofs, cdat} : {4'h4, fisw, fbar, faddr, fdat};
            if (expq.size() == 0) check("stray write", got, 24'h0);
            else check("byte write", {8'h0, got}, {8'h0, expq.pop_front()});
        end
    end
    initial begin
        logic [31:0] q;
        rs = xs(32'h0000_005E);
        ee_u.mem = '{default: 16'hFFFF};
        ee_u.mem[0] = {HDR_SIGNATURE, 4'hF};
        ee_u.mem[1] = {1'b1, 7'h04, rs[7:0]};
        ee_u.mem[2] = 16'h0211;
        ee_u.mem[3] = 16'h8034;
        ee_u.mem[4] = 16'h0312;
        ee_u.mem[5] = 16'h8000;
        ee_u.mem[6] = 16'h86FF;
        ee_u.mem[7] = 16'h3D02;
        ee_u.mem[8] = 16'h0000;
        ee_u.mem[9] = 16'h8820;
        ee_u.mem[10] = {8'h00, rs[15:8]};
        expq.push_back({8'h10, 8'h04, rs[7:0]});
        expq.push_back(24'h200034);
        expq.push_back(24'h200312);
        expq.push_back(24'h300610);
        expq.push_back(24'h303D02);
        expq.push_back({16'h4820, rs[15:8]});
        repeat (6) @(posedge i_clock);
        i_srst <= 1'b0;
        bus(1'b0, REG_STATUS, 32'h0, q);
        check("loading flag", q[0], 1'b1);
        check("retry", retry, 1'b1);
        bus(1'b1, 4'hC, xs(rs), q);
        bus(1'b0, 4'hC, 32'h0, q);
        check("unmapped read", q, UNMAPPED_RD);
        wait_done(70000);
        check("valid", valid, 1'b1);
        bus(1'b0, REG_CTRL, 32'h0, q);
        check("ctrl valid bit", q[28], 1'b1);
        bus(1'b0, REG_WORDS, 32'h0, q);
        check("words fetched", q[7:0], 8'h0B);
        check("writes left", expq.size(), 0);
        ee_u.mem[0] = 16'h1235;
        bus(1'b1, REG_CTRL, 32'h2000_0000, q);
        repeat (4) @(posedge i_clock);
        check("reload retry", retry, 1'b1);
        wait_done(10000);
        check("valid after bad header", valid, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
